// [common/sdiio_pkg.sv]
// Purpose: shared constants for the bidirectional serial-video port control
// Assumes: core_clk at 10 MHz, management port abstracted to strobes
// Notes: Function list below
package sdiio_pkg;

  // *****************************
  // pin levels
  // *****************************
  localparam int         LVL_W      = 8;
  localparam int         LVL_FULL_I = 255;
  localparam logic [7:0] LVL_FULL   = 8'(LVL_FULL_I);
  localparam logic [7:0] LVL_TH_LR  = 8'(LVL_FULL_I * 2 / 10);
  localparam logic [7:0] LVL_TH_RF  = 8'(LVL_FULL_I * 5 / 10);
  localparam logic [7:0] LVL_TH_FH  = 8'(LVL_FULL_I * 8 / 10);
  localparam logic [7:0] LVL_FLOAT  = 8'(LVL_FULL_I * 2 / 3);
  localparam logic [7:0] LVL_R_NOM  = 8'(LVL_FULL_I / 3);
  localparam logic [7:0] LVL_ZERO   = 8'h00;
  localparam logic [1:0] ST_L       = 2'h0;
  localparam logic [1:0] ST_R       = 2'h1;
  localparam logic [1:0] ST_F       = 2'h2;
  localparam logic [1:0] ST_H       = 2'h3;
  localparam int         STRAP_N    = 3;
  localparam int         STRAP_DIR  = 0;
  localparam int         STRAP_HSEL = 1;
  localparam int         STRAP_SSEL = 2;

  // *****************************
  // timing
  // *****************************
  localparam int CLK_HZ    = 10_000_000;
  localparam int TLOCK_MS  = 5;
  localparam int TPOR_MS   = 50;
  localparam int TSPI_MS   = 16;
  localparam int LOCK_CYC  = TLOCK_MS * (CLK_HZ / 1000);
  localparam int POR_CYC   = TPOR_MS * (CLK_HZ / 1000);
  localparam int SPI_CYC   = TSPI_MS * (CLK_HZ / 1000);
  localparam int BOOT_CYC  = (POR_CYC > SPI_CYC) ? POR_CYC : SPI_CYC;
  localparam int CNT_W     = 20;

  // *****************************
  // device management registers
  // *****************************
  localparam logic [7:0] DREG_STATUS  = 8'h00;
  localparam logic [7:0] DREG_PINCFG  = 8'h01;
  localparam logic [7:0] DREG_INTFLAG = 8'h02;
  localparam logic [1:0] PIN_LOCK     = 2'h0;
  localparam logic [1:0] PIN_CARRIER  = 2'h1;
  localparam logic [1:0] PIN_INT      = 2'h2;
  localparam logic [1:0] PINCFG_RST   = 2'h0;
  localparam int         INT_LOCKLOST = 0;
  localparam int         INT_CARLOST  = 1;

  // *****************************
  // host command registers
  // *****************************
  localparam logic [7:0] HREG_CTRL   = 8'h00;
  localparam logic [7:0] HREG_MADDR  = 8'h01;
  localparam logic [7:0] HREG_MWDATA = 8'h02;
  localparam logic [7:0] HREG_MREAD  = 8'h03;
  localparam logic [7:0] HREG_STATUS = 8'h04;
  localparam logic [6:0] CTRL_RST    = 7'h68;
  localparam int         CTRL_EN     = 6;
  localparam int         HST_REFUSED = 1;

  typedef enum logic [1:0] {
    CDR_RESET   = 2'b00,
    CDR_ACQUIRE = 2'b01,
    CDR_LOCKED  = 2'b10
  } sdiio_cdr_type;

  typedef enum logic [1:0] {
    HST_BOOT  = 2'b00,
    HST_IDLE  = 2'b01,
    HST_RDWT  = 2'b10
  } sdiio_host_type;

endpackage

// [common/sdiio_link_if.sv]
// Purpose: pins between the port device and its host controller
// Assumes: one clock; straps resolved here from code and enable
// Notes: open strap settles at the internal divider level
`timescale 1ns/1ps
`default_nettype none
interface sdiio_link_if;
  logic [sdiio_pkg::STRAP_N-1:0][7:0] strapCode;
  logic [sdiio_pkg::STRAP_N-1:0]      strapOeN;
  wire  [sdiio_pkg::STRAP_N-1:0][7:0] strapLevel;
  logic                               enablePin;
  logic                               hostInData;
  logic                               hostInCarrier;
  logic                               hostOutData;
  logic                               hostOutEn;
  logic                               statusN;
  logic                               mgmtWr;
  logic                               mgmtRd;
  logic [7:0]                         mgmtAddr;
  logic [7:0]                         mgmtWdata;
  logic [7:0]                         mgmtRdata;

  // ***************************
  // strap wire level
  // ***************************
  genvar i;
  generate
    for (i = 0; i < sdiio_pkg::STRAP_N; i++) begin : g_strap
      assign strapLevel[i] = strapOeN[i] ? sdiio_pkg::LVL_FLOAT
                                         : strapCode[i];
    end
  endgenerate

  modport dev (
    input  strapLevel, enablePin, hostInData, hostInCarrier,
    input  mgmtWr, mgmtRd, mgmtAddr, mgmtWdata,
    output hostOutData, hostOutEn, statusN, mgmtRdata
  );
  modport host (
    output strapCode, strapOeN, enablePin, hostInData, hostInCarrier,
    output mgmtWr, mgmtRd, mgmtAddr, mgmtWdata,
    input  hostOutData, hostOutEn, statusN, mgmtRdata
  );
endinterface
`default_nettype wire

// [design/sdiio_level_decode.sv]
// Purpose: synchronise and decode one four-level strap
// Assumes: level code is full-scale at the supply level
// Notes: two flops before the compare
`timescale 1ns/1ps
`default_nettype none
module sdiio_level_decode (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] level,
  output logic      [1:0] state
);
  logic [7:0] syncA_q;
  logic [7:0] syncB_q;
  logic [1:0] state_d;
  logic [1:0] state_q;

  assign state_d = (syncB_q < sdiio_pkg::LVL_TH_LR) ? sdiio_pkg::ST_L :
                   (syncB_q < sdiio_pkg::LVL_TH_RF) ? sdiio_pkg::ST_R :
                   (syncB_q < sdiio_pkg::LVL_TH_FH) ? sdiio_pkg::ST_F :
                                                      sdiio_pkg::ST_H;
  assign state = state_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      syncA_q <= sdiio_pkg::LVL_ZERO;
      syncB_q <= sdiio_pkg::LVL_ZERO;
      state_q <= sdiio_pkg::ST_L;
    end else begin
      syncA_q <= level;
      syncB_q <= syncA_q;
      state_q <= state_d;
    end
  end
endmodule
`default_nettype wire

// [design/sdiio_device.sv]
// Purpose: mode, path and power control of the bidirectional port
// Assumes: management strobes on core_clk; straps and carriers async
// Notes: serial data modelled one bit per cycle
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sdiio_device #(
  parameter int LOCK_EDGES = sdiio_pkg::LOCK_CYC,
  parameter int POR_WAIT   = sdiio_pkg::POR_CYC
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  sdiio_link_if.dev link,
  input  wire logic lineRxData,
  input  wire logic lineRxCarrier,
  output logic      lineTxData,
  output logic      lineTxEn,
  output logic      lineEqEn,
  output logic      secTxData,
  output logic      secTxEn,
  output logic      cdrLocked,
  output logic      powerSave,
  output logic      powerDown
);
  // ***************************
  // strap and pin capture
  // ***************************
  logic [sdiio_pkg::STRAP_N-1:0][1:0] strapSt;
  logic [2:0] pinA_q;
  logic [2:0] pinB_q;

  genvar i;
  generate
    for (i = 0; i < sdiio_pkg::STRAP_N; i++) begin : g_dec
      sdiio_level_decode u_dec (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .level    (link.strapLevel[i]),
        .state    (strapSt[i])
      );
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pinA_q <= 3'h0;
      pinB_q <= 3'h0;
    end else begin
      pinA_q <= {link.enablePin, link.hostInCarrier, lineRxCarrier};
      pinB_q <= pinA_q;
    end
  end

  // ***************************
  // mode decode
  // ***************************
  wire enabled    = pinB_q[2];
  wire hostCar    = pinB_q[1];
  wire lineCar    = pinB_q[0];
  wire driverMode = strapSt[sdiio_pkg::STRAP_DIR] != sdiio_pkg::ST_L;
  wire hostSelLow = strapSt[sdiio_pkg::STRAP_HSEL] == sdiio_pkg::ST_L;
  wire secSelLow  = strapSt[sdiio_pkg::STRAP_SSEL] == sdiio_pkg::ST_L;
  wire carrier    = driverMode ? hostCar : lineCar;
  wire active     = enabled & carrier;
  wire rxSel      = driverMode ? link.hostInData : lineRxData;

  logic modeQ_q;
  wire  modeChange = driverMode != modeQ_q;

  // ***************************
  // clock recovery
  // ***************************
  // lock timing comes only from edges of the incoming stream
  sdiio_pkg::sdiio_cdr_type cdr_q;
  sdiio_pkg::sdiio_cdr_type cdr_d;
  logic [sdiio_pkg::CNT_W-1:0] edgeCnt_q;
  logic rxPrev_q;
  logic recData_q;
  wire  rxEdge  = rxSel != rxPrev_q;
  wire  lockHit = edgeCnt_q == sdiio_pkg::CNT_W'(LOCK_EDGES - 1);

  always_comb begin
    cdr_d = cdr_q;
    case (cdr_q)
      sdiio_pkg::CDR_RESET: begin
        cdr_d = active ? sdiio_pkg::CDR_ACQUIRE : sdiio_pkg::CDR_RESET;
      end
      sdiio_pkg::CDR_ACQUIRE: begin
        if (rxEdge && lockHit) begin
          cdr_d = sdiio_pkg::CDR_LOCKED;
        end
      end
      sdiio_pkg::CDR_LOCKED: begin
        cdr_d = sdiio_pkg::CDR_LOCKED;
      end
      default: begin
        cdr_d = sdiio_pkg::CDR_RESET;
      end
    endcase
    if (modeChange || !active) begin
      cdr_d = sdiio_pkg::CDR_RESET;
    end
  end

  wire locked = cdr_q == sdiio_pkg::CDR_LOCKED;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cdr_q     <= sdiio_pkg::CDR_RESET;
      edgeCnt_q <= '0;
      rxPrev_q  <= 1'b0;
      recData_q <= 1'b0;
      modeQ_q   <= 1'b0;
    end else begin
      cdr_q     <= cdr_d;
      rxPrev_q  <= rxSel;
      recData_q <= rxSel;
      modeQ_q   <= driverMode;
      if (cdr_q != sdiio_pkg::CDR_ACQUIRE) begin
        edgeCnt_q <= '0;
      end else if (rxEdge) begin
        edgeCnt_q <= edgeCnt_q + 1'b1;
      end
    end
  end

  // ***************************
  // path enables and data
  // ***************************
  // outputs carry data only once locked; unlocked data would be garbage
  wire eqEn_d    = enabled & ~driverMode;
  wire drvEn_d   = active & driverMode & ~modeChange;
  wire hostEn_d  = active & (~driverMode | hostSelLow);
  wire secEn_d   = active & secSelLow;
  wire outBit    = recData_q & locked;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lineEqEn         <= 1'b0;
      lineTxEn         <= 1'b0;
      lineTxData       <= 1'b0;
      secTxEn          <= 1'b0;
      secTxData        <= 1'b0;
      link.hostOutEn   <= 1'b0;
      link.hostOutData <= 1'b0;
      cdrLocked        <= 1'b0;
      powerSave        <= 1'b0;
      powerDown        <= 1'b1;
    end else begin
      lineEqEn         <= eqEn_d & ~modeChange;
      lineTxEn         <= drvEn_d;
      lineTxData       <= outBit & drvEn_d;
      secTxEn          <= secEn_d;
      secTxData        <= outBit & secEn_d;
      link.hostOutEn   <= hostEn_d;
      link.hostOutData <= outBit & hostEn_d;
      cdrLocked        <= locked & ~modeChange;
      powerSave        <= enabled & ~carrier;
      powerDown        <= ~enabled;
    end
  end

  // ***************************
  // management port
  // ***************************
  logic [sdiio_pkg::CNT_W-1:0] porCnt_q;
  logic       ready_q;
  logic [1:0] pinCfg_q;
  logic [1:0] intFlag_q;
  logic       lockPrev_q;
  logic       carPrev_q;
  logic [7:0] rdData_q;

  wire wrOk    = link.mgmtWr & ready_q;
  wire rdOk    = link.mgmtRd & ready_q;
  wire wrCfg   = wrOk & (link.mgmtAddr == sdiio_pkg::DREG_PINCFG);
  wire wrInt   = wrOk & (link.mgmtAddr == sdiio_pkg::DREG_INTFLAG);
  wire [1:0] intSet = {carPrev_q & ~carrier, lockPrev_q & ~locked};
  wire [1:0] intClr = wrInt ? link.mgmtWdata[1:0] : 2'h0;
  // a new event in the clear cycle survives
  wire [1:0] intNext = (intFlag_q & ~intClr) | intSet;
  wire [7:0] statusWord = {2'h0, ~enabled, enabled & ~carrier,
                           cdr_q == sdiio_pkg::CDR_RESET, driverMode,
                           carrier, locked};
  wire [7:0] rdMux =
    (link.mgmtAddr == sdiio_pkg::DREG_STATUS)  ? statusWord :
    (link.mgmtAddr == sdiio_pkg::DREG_PINCFG)  ? {6'h00, pinCfg_q} :
    (link.mgmtAddr == sdiio_pkg::DREG_INTFLAG) ? {6'h00, intFlag_q} :
                                                 8'h00;
  wire statusAct =
    (pinCfg_q == sdiio_pkg::PIN_LOCK)    ? locked :
    (pinCfg_q == sdiio_pkg::PIN_CARRIER) ? carrier :
    (pinCfg_q == sdiio_pkg::PIN_INT)     ? |intFlag_q : 1'b0;

  assign link.mgmtRdata = rdData_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      porCnt_q     <= '0;
      ready_q      <= 1'b0;
      pinCfg_q     <= sdiio_pkg::PINCFG_RST;
      intFlag_q    <= 2'h0;
      lockPrev_q   <= 1'b0;
      carPrev_q    <= 1'b0;
      rdData_q     <= 8'h00;
      link.statusN <= 1'b1;
    end else begin
      if (!ready_q) begin
        porCnt_q <= porCnt_q + 1'b1;
        ready_q  <= porCnt_q == sdiio_pkg::CNT_W'(POR_WAIT - 1);
      end
      if (wrCfg) begin
        pinCfg_q <= link.mgmtWdata[1:0];
      end
      intFlag_q    <= intNext;
      lockPrev_q   <= locked;
      carPrev_q    <= carrier;
      rdData_q     <= rdOk ? rdMux : 8'h00;
      link.statusN <= ~statusAct;
    end
  end
endmodule
`default_nettype wire

// [design/sdiio_host.sv]
// Purpose: host controller driving straps and management access
// Assumes: software port, read data one cycle after read strobe
// Notes: all management requests refused and flagged until boot wait ends
`timescale 1ns/1ps
`default_nettype none
module sdiio_host #(
  parameter int BOOT_WAIT = sdiio_pkg::BOOT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  sdiio_link_if.host      link,
  input  wire logic [7:0] cmdAddr,
  input  wire logic [7:0] cmdWdata,
  input  wire logic       cmdWr,
  input  wire logic       cmdRd,
  output logic      [7:0] cmdRdata,
  input  wire logic       txData,
  input  wire logic       txCarrier,
  output logic            rxData,
  output logic            rxEn
);
  sdiio_pkg::sdiio_host_type st_q;
  logic [sdiio_pkg::CNT_W-1:0] bootCnt_q;
  logic [6:0] ctrl_q;
  logic [7:0] mAddr_q;
  logic [7:0] mRead_q;
  logic       refused_q;
  logic       rdValid_q;
  logic [1:0] statSync_q;
  logic       rdCap_q;

  wire bootDone = st_q != sdiio_pkg::HST_BOOT;
  wire idle     = st_q == sdiio_pkg::HST_IDLE;
  wire wrCtrl   = cmdWr & (cmdAddr == sdiio_pkg::HREG_CTRL);
  wire wrMAddr  = cmdWr & (cmdAddr == sdiio_pkg::HREG_MADDR);
  wire wrMData  = cmdWr & (cmdAddr == sdiio_pkg::HREG_MWDATA);
  wire wrMRead  = cmdWr & (cmdAddr == sdiio_pkg::HREG_MREAD);
  wire wrStat   = cmdWr & (cmdAddr == sdiio_pkg::HREG_STATUS);
  wire mReq     = wrMData | wrMRead;
  wire issueWr  = wrMData & idle;
  wire issueRd  = wrMRead & idle;
  wire refuse   = mReq & ~idle;
  wire clrRef   = wrStat & cmdWdata[sdiio_pkg::HST_REFUSED];
  wire [7:0] statusWord = {4'h0, rdValid_q, statSync_q[1], refused_q,
                           bootDone};
  wire [7:0] rdMux =
    (cmdAddr == sdiio_pkg::HREG_CTRL)   ? {1'b0, ctrl_q} :
    (cmdAddr == sdiio_pkg::HREG_MADDR)  ? mAddr_q :
    (cmdAddr == sdiio_pkg::HREG_MREAD)  ? mRead_q :
    (cmdAddr == sdiio_pkg::HREG_STATUS) ? statusWord : 8'h00;

  // ***************************
  // sequencing
  // ***************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q      <= sdiio_pkg::HST_BOOT;
      bootCnt_q <= '0;
    end else begin
      case (st_q)
        sdiio_pkg::HST_BOOT: begin
          bootCnt_q <= bootCnt_q + 1'b1;
          if (bootCnt_q == sdiio_pkg::CNT_W'(BOOT_WAIT - 1)) begin
            st_q <= sdiio_pkg::HST_IDLE;
          end
        end
        sdiio_pkg::HST_IDLE: begin
          if (issueRd) begin
            st_q <= sdiio_pkg::HST_RDWT;
          end
        end
        sdiio_pkg::HST_RDWT: begin
          st_q <= sdiio_pkg::HST_IDLE;
        end
        default: begin
          st_q <= sdiio_pkg::HST_BOOT;
        end
      endcase
    end
  end

  // ***************************
  // registers and link drive
  // ***************************
  // straps hold their level from reset, so power-up sees the strap
  genvar i;
  generate
    for (i = 0; i < sdiio_pkg::STRAP_N; i++) begin : g_pin
      localparam logic [1:0] RST_LVL = sdiio_pkg::CTRL_RST[2*i+1:2*i];
      // reset drives the control reset level, so no open-pin glitch
      wire [1:0] lvl = sys_rst ? RST_LVL : ctrl_q[2*i+1:2*i];
      always_ff @(posedge core_clk) begin
        link.strapCode[i] <= (lvl == sdiio_pkg::ST_H) ? sdiio_pkg::LVL_FULL :
                             (lvl == sdiio_pkg::ST_R) ? sdiio_pkg::LVL_R_NOM :
                                                        sdiio_pkg::LVL_ZERO;
        link.strapOeN[i]  <= lvl == sdiio_pkg::ST_F;
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q             <= sdiio_pkg::CTRL_RST;
      mAddr_q            <= 8'h00;
      mRead_q            <= 8'h00;
      refused_q          <= 1'b0;
      rdValid_q          <= 1'b0;
      rdCap_q            <= 1'b0;
      statSync_q         <= 2'h3;
      cmdRdata           <= 8'h00;
      rxData             <= 1'b0;
      rxEn               <= 1'b0;
      link.enablePin     <= 1'b0;
      link.hostInData    <= 1'b0;
      link.hostInCarrier <= 1'b0;
      link.mgmtWr        <= 1'b0;
      link.mgmtRd        <= 1'b0;
      link.mgmtAddr      <= 8'h00;
      link.mgmtWdata     <= 8'h00;
    end else begin
      if (wrCtrl) begin
        ctrl_q <= cmdWdata[6:0];
      end
      if (wrMAddr) begin
        mAddr_q <= cmdWdata;
      end
      // read data stands the cycle after the strobe, so capture then
      if (rdCap_q) begin
        mRead_q   <= link.mgmtRdata;
        rdValid_q <= 1'b1;
      end else if (issueRd) begin
        rdValid_q <= 1'b0;
      end
      refused_q          <= refuse | (refused_q & ~clrRef);
      rdCap_q            <= link.mgmtRd;
      statSync_q         <= {statSync_q[0], link.statusN};
      cmdRdata           <= cmdRd ? rdMux : 8'h00;
      rxData             <= link.hostOutData;
      rxEn               <= link.hostOutEn;
      link.enablePin     <= ctrl_q[sdiio_pkg::CTRL_EN];
      link.hostInData    <= txData;
      link.hostInCarrier <= txCarrier;
      link.mgmtWr        <= issueWr;
      link.mgmtRd        <= issueRd;
      if (mReq && idle) begin
        link.mgmtAddr  <= mAddr_q;
        link.mgmtWdata <= cmdWdata;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/sdiio_link_sva.sv]
// Purpose: checks on the port device pins and mode outputs
// Assumes: one clock, synchronous active high reset
// Notes: windows allow strap sync plus the enable register
`timescale 1ns/1ps
`default_nettype none
module sdiio_link_sva (
  input wire logic                               core_clk,
  input wire logic                               sys_rst,
  input wire logic [sdiio_pkg::STRAP_N-1:0][7:0] strapLevel,
  input wire logic                               enablePin,
  input wire logic                               lineRxCarrier,
  input wire logic                               mgmtRd,
  input wire logic [7:0]                         mgmtRdata,
  input wire logic                               hostOutEn,
  input wire logic                               lineEqEn,
  input wire logic                               lineTxEn,
  input wire logic                               cdrLocked,
  input wire logic                               powerSave,
  input wire logic                               powerDown
);
  // ****************
  // assertions
  // ****************
  wire logic dirL;
  wire logic dirH;
  // levels equal to a threshold are never driven, so no ambiguity
  assign dirL = strapLevel[0] < sdiio_pkg::LVL_TH_LR;
  assign dirH = strapLevel[0] > sdiio_pkg::LVL_TH_LR;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_one_direction: assert property (
    !(lineEqEn && lineTxEn)) else $error("both line directions on");
  a_rdata_one_cycle: assert property (
    !$past(mgmtRd) |-> mgmtRdata == 8'h00) else $error("stray read data");
  a_equalizer_mode_on: assert property (
    (dirL && enablePin && lineRxCarrier) [*6] |-> hostOutEn && lineEqEn)
    else $error("equalizer path not on");
  a_eq_no_driver: assert property (
    dirL [*6] |-> !lineTxEn) else $error("driver on in equalizer mode");
  a_drv_no_eq: assert property (
    dirH [*6] |-> !lineEqEn) else $error("equalizer on in driver mode");
  a_relock_after_change: assert property (
    $changed(dirL) |-> ##6 (!cdrLocked) [*4])
    else $error("lock kept across mode change");
  a_pd_follows_enable: assert property (
    (!enablePin) [*4] |-> powerDown) else $error("no power-down");
  a_pd_outputs_off: assert property (
    powerDown [*3] |-> !hostOutEn && !lineEqEn && !lineTxEn)
    else $error("output on in power-down");
  a_save_no_carrier: assert property (
    (enablePin && !lineRxCarrier && dirL) [*6] |-> powerSave)
    else $error("no power save");
  c_mode_change: cover property (dirL ##1 !dirL);
  c_lock: cover property ($rose(cdrLocked));
  c_power_down: cover property ($rose(powerDown));
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: drives host command port and line side of the port device
// Assumes: shortened lock, power-on and boot counts
// Notes: stream pattern is a function of a cycle count
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic        core_clk;
  logic        sys_rst;
  logic [7:0]  cmdAddr;
  logic [7:0]  cmdWdata;
  logic        cmdWr;
  logic        cmdRd;
  logic [7:0]  cmdRdata;
  logic        txData;
  logic        txCarrier;
  logic        rxData;
  logic        rxEn;
  logic        lineRxData;
  logic        lineRxCarrier;
  logic        lineTxData, lineTxEn, lineEqEn, secTxData, secTxEn;
  logic        cdrLocked, powerSave, powerDown;
  logic [31:0] cyc = 32'h0000_0000;
  int          mismatches;
  int          n_tests;
  // ****************
  // design
  // ****************
  sdiio_link_if sdiio_link_if_i ();
  sdiio_device #(.LOCK_EDGES(8), .POR_WAIT(16)) sdiio_device_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(sdiio_link_if_i),
    .lineRxData(lineRxData), .lineRxCarrier(lineRxCarrier),
    .lineTxData(lineTxData), .lineTxEn(lineTxEn), .lineEqEn(lineEqEn),
    .secTxData(secTxData), .secTxEn(secTxEn), .cdrLocked(cdrLocked),
    .powerSave(powerSave), .powerDown(powerDown));
  sdiio_host #(.BOOT_WAIT(20)) sdiio_host_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(sdiio_link_if_i),
    .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWr(cmdWr),
    .cmdRd(cmdRd), .cmdRdata(cmdRdata), .txData(txData),
    .txCarrier(txCarrier), .rxData(rxData), .rxEn(rxEn));
  sdiio_link_sva sdiio_link_sva_i (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .strapLevel(sdiio_link_if_i.strapLevel),
    .enablePin(sdiio_link_if_i.enablePin),
    .lineRxCarrier(lineRxCarrier), .mgmtRd(sdiio_link_if_i.mgmtRd),
    .mgmtRdata(sdiio_link_if_i.mgmtRdata),
    .hostOutEn(sdiio_link_if_i.hostOutEn), .lineEqEn(lineEqEn),
    .lineTxEn(lineTxEn), .cdrLocked(cdrLocked),
    .powerSave(powerSave), .powerDown(powerDown));
  // ****************
  // stimulus
  // ****************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic pat(input logic [31:0] x);
    return x[1] ^ x[3];
  endfunction
  // host input inverted so a swapped route shows up
  always @(posedge core_clk) begin
    cyc <= cyc + 32'h0000_0001;
    lineRxData <= pat(cyc);
    txData <= ~pat(cyc);
  end
  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cmdAddr <= a;
    cmdWdata <= d;
    cmdWr <= 1'b1;
    @(posedge core_clk);
    cmdWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    cmdAddr <= a;
    cmdRd <= 1'b1;
    @(posedge core_clk);
    cmdRd <= 1'b0;
    @(negedge core_clk);
    d = cmdRdata;
  endtask
  task automatic mread(input logic [7:0] a, output logic [7:0] d);
    wr(sdiio_pkg::HREG_MADDR, a);
    wr(sdiio_pkg::HREG_MREAD, 8'h00);
    repeat (4) @(posedge core_clk);
    rd(sdiio_pkg::HREG_MREAD, d);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_lock();
    int k;
    k = 0;
    while (cdrLocked !== 1'b1 && k < 300) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 300) begin
      mismatches++;
      print_verdict();
    end
  endtask
  // sel: 0 host side, 1 line driver, 2 secondary
  task automatic chk_stream(input string nm, input int sel, input int dly,
                            input logic inv);
    logic got;
    repeat (8) begin
      @(negedge core_clk);
      got = (sel == 0) ? rxData : (sel == 1) ? lineTxData : secTxData;
      `CHK(nm, pat(cyc - dly) ^ inv, got)
    end
  endtask
  // ****************
  // scenarios
  // ****************
  initial begin
    logic [7:0] d;
    sys_rst = 1'b1;
    cmdAddr = 8'h00;
    cmdWdata = 8'h00;
    cmdWr = 1'b0;
    cmdRd = 1'b0;
    txCarrier = 1'b0;
    lineRxCarrier = 1'b1;
    mismatches = 0;
    n_tests = 0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    mread(sdiio_pkg::DREG_STATUS, d);
    rd(sdiio_pkg::HREG_STATUS, d);
    `CHK("early access", 2'b10, d[1:0])
    settle(20);
    wr(sdiio_pkg::HREG_STATUS, 8'h02);
    rd(sdiio_pkg::HREG_STATUS, d);
    `CHK("boot done", 2'b01, d[1:0])
    wait_lock();
    settle(2);
    `CHK("eq enables", 4'b1010, {lineEqEn, lineTxEn, rxEn, secTxEn})
    chk_stream("eq host out", 0, 4, 1'b0);
    wr(sdiio_pkg::HREG_CTRL, 8'h48);
    settle(8);
    chk_stream("loop thru", 2, 3, 1'b0);
    mread(sdiio_pkg::DREG_STATUS, d);
    `CHK("dev status", 6'h03, d[5:0])
    wr(sdiio_pkg::HREG_MADDR, sdiio_pkg::DREG_PINCFG);
    wr(sdiio_pkg::HREG_MWDATA, 8'h03);
    settle(6);
    rd(sdiio_pkg::HREG_STATUS, d);
    `CHK("status pin off", 1'b1, d[2])
    wr(sdiio_pkg::HREG_MWDATA, 8'h00);
    settle(6);
    rd(sdiio_pkg::HREG_STATUS, d);
    `CHK("status pin lock", 1'b0, d[2])
    @(posedge core_clk);
    txCarrier <= 1'b1;
    wr(sdiio_pkg::HREG_CTRL, 8'h43);
    settle(6);
    `CHK("relock", 1'b0, cdrLocked)
    wait_lock();
    settle(2);
    `CHK("cd enables", 4'b0111, {lineEqEn, lineTxEn, rxEn, secTxEn})
    chk_stream("cd line", 1, 4, 1'b1);
    chk_stream("cd sec", 2, 4, 1'b1);
    chk_stream("cd loopback", 0, 5, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(sdiio_pkg::HREG_CTRL, 8'h40 | 8'(i));
      settle(8);
      `CHK("dir level", {i == 0, i != 0}, {lineEqEn, lineTxEn})
    end
    for (int i = 0; i < 4; i++) begin
      wr(sdiio_pkg::HREG_CTRL, 8'h43 | 8'(i << 2));
      settle(8);
      `CHK("host sel", i == 0, rxEn)
    end
    @(posedge core_clk);
    txCarrier <= 1'b0;
    settle(8);
    `CHK("power save", 2'b10, {powerSave, lineTxEn})
    @(posedge core_clk);
    lineRxCarrier <= 1'b0;
    wr(sdiio_pkg::HREG_CTRL, 8'h40);
    settle(8);
    `CHK("eq power save", 2'b10, {powerSave, rxEn})
    wr(sdiio_pkg::HREG_CTRL, 8'h03);
    settle(8);
    `CHK("power down", 4'b1000, {powerDown, lineTxEn, rxEn, secTxEn})
    mread(sdiio_pkg::DREG_STATUS, d);
    `CHK("pd status", 1'b1, d[5])
    mread(sdiio_pkg::DREG_INTFLAG, d);
    `CHK("int flags", 2'h3, d[1:0])
    wr(sdiio_pkg::HREG_MADDR, sdiio_pkg::DREG_PINCFG);
    wr(sdiio_pkg::HREG_MWDATA, 8'h02);
    settle(6);
    rd(sdiio_pkg::HREG_STATUS, d);
    `CHK("status pin int", 1'b0, d[2])
    wr(sdiio_pkg::HREG_MADDR, sdiio_pkg::DREG_INTFLAG);
    wr(sdiio_pkg::HREG_MWDATA, 8'h03);
    settle(6);
    rd(sdiio_pkg::HREG_STATUS, d);
    `CHK("int cleared", 1'b1, d[2])
    print_verdict();
  end
endmodule
`default_nettype wire
